/* File: hw/pfp_defines.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock, one-second protection tick
// Notes:   times are kept in seconds; the tick period is derived from the clock
`ifndef PFP_DEFINES_SVH
`define PFP_DEFINES_SVH

// clock and tick
`define PFP_CLK_PERIOD_NS     10
`define PFP_TICK_PERIOD_NS    1000000000

// register byte offsets
`define PFP_ADDR_CTRL         8'h00
`define PFP_ADDR_DRY_DELAY    8'h04
`define PFP_ADDR_RESTART_DROP 8'h08
`define PFP_ADDR_SETPOINT     8'h0C
`define PFP_ADDR_STATUS       8'h10
`define PFP_ADDR_IRQ_STATUS   8'h14
`define PFP_ADDR_IRQ_MASK     8'h18

// reset values and restart drop step
`define PFP_RST_MODE          2'h0
`define PFP_RST_DRY_DELAY     16'h000A
`define PFP_RST_RESTART_DROP  8'h03
`define PFP_RST_SETPOINT      8'h1E
`define PFP_RST_IRQ_MASK      8'h00
`define PFP_RESTART_DROP_STEP 8'h01

// block vector bit positions
`define PFP_BIT_DRY           0
`define PFP_BIT_OVERLOAD      1
`define PFP_BIT_CYCLING       2
`define PFP_BIT_SHORT         3
`define PFP_BIT_INTERNAL      4
`define PFP_BIT_OVERHEAT      5
`define PFP_BIT_SUPPLY        6
`define PFP_BIT_SENSOR        7
`define PFP_NUM_BLOCKS        8

// status register fields
`define PFP_STATUS_RUN_BIT    8
`define PFP_STATUS_CODE_LSB   12

// timing in seconds and retry attempt counts
`define PFP_SHORT_HOLD_S      17'd10
`define PFP_INTERNAL_HOLD_S   17'd900
`define PFP_RETRY_FAST_S      17'd600
`define PFP_RETRY_HOURLY_S    17'd3600
`define PFP_RETRY_DAILY_S     17'd86400
`define PFP_RETRY_FAST_N      5'd6
`define PFP_RETRY_HOURLY_N    5'd24
`define PFP_RETRY_DAILY_N     5'd30

`endif

/* File: hw/pfp_pkg.sv */
// Purpose: shared types of the pump fault-protection manager
// Assumes: constants live in pfp_defines.svh
// Notes:   display codes are ordered by priority, lowest code wins
package pfp_pkg;

  typedef enum logic [1:0] {
    PFP_CYCLE_OFF   = 2'b00,
    PFP_CYCLE_BASIC = 2'b01,
    PFP_CYCLE_SMART = 2'b10
  } pfp_cycle_mode_e;

  typedef enum logic [2:0] {
    PFP_RETRY_IDLE   = 3'b000,
    PFP_RETRY_FAST   = 3'b001,
    PFP_RETRY_HOURLY = 3'b010,
    PFP_RETRY_DAILY  = 3'b011,
    PFP_RETRY_SPENT  = 3'b100
  } pfp_retry_e;

  typedef enum logic [3:0] {
    PFP_CODE_NONE     = 4'b0000,
    PFP_CODE_SHORT    = 4'b0001,
    PFP_CODE_INTERNAL = 4'b0010,
    PFP_CODE_OVERHEAT = 4'b0011,
    PFP_CODE_SUPPLY   = 4'b0100,
    PFP_CODE_OVERLOAD = 4'b0101,
    PFP_CODE_SENSOR   = 4'b0110,
    PFP_CODE_DRY      = 4'b0111,
    PFP_CODE_CYCLING  = 4'b1000
  } pfp_code_e;

endpackage

/* File: hw/pfp_retry_if.sv */
// Purpose: carrier between the manager and one retry scheduler
// Assumes: all signals on the system clock
// Notes:   manual_clr and the dry-run trigger are one-cycle pulses; the overload trigger is a level
`timescale 1ns/1ps
interface pfp_retry_if;
  logic tick;
  logic trigger;
  logic cond;
  logic manual_clr;
  logic blocked;

  modport ctrl  (output tick, output trigger, output cond, output manual_clr, input blocked);
  modport retry (input tick, input trigger, input cond, input manual_clr, output blocked);
endinterface

/* File: hw/pfp_sync.sv */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage is visible
`timescale 1ns/1ps
module pfp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: hw/pfp_retry.sv */
// Purpose: timed automatic retry schedule for one blockage
// Assumes: one tick per second; cond high means the fault is still present
// Notes:   after the last daily attempt the block stays until a manual reset
`timescale 1ns/1ps
`include "pfp_defines.svh"
module pfp_retry (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control side
  pfp_retry_if.retry rif
);
  pfp_pkg::pfp_retry_e state;
  logic [16:0]         secs;
  logic [4:0]          tries;
  logic [16:0]         interval;
  logic [4:0]          limit;
  logic                timing;

  always_comb begin
    unique case (state)
      pfp_pkg::PFP_RETRY_FAST: begin
        interval = `PFP_RETRY_FAST_S;
        limit    = `PFP_RETRY_FAST_N;
      end
      pfp_pkg::PFP_RETRY_HOURLY: begin
        interval = `PFP_RETRY_HOURLY_S;
        limit    = `PFP_RETRY_HOURLY_N;
      end
      pfp_pkg::PFP_RETRY_DAILY: begin
        interval = `PFP_RETRY_DAILY_S;
        limit    = `PFP_RETRY_DAILY_N;
      end
      default: begin
        interval = 17'd0;
        limit    = 5'd0;
      end
    endcase
  end

  assign timing      = (state == pfp_pkg::PFP_RETRY_FAST) || (state == pfp_pkg::PFP_RETRY_HOURLY)
                       || (state == pfp_pkg::PFP_RETRY_DAILY);
  assign rif.blocked = (state != pfp_pkg::PFP_RETRY_IDLE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= pfp_pkg::PFP_RETRY_IDLE;
      secs  <= 17'd0;
      tries <= 5'd0;
    end else if (rif.trigger && state == pfp_pkg::PFP_RETRY_IDLE) begin
      state <= pfp_pkg::PFP_RETRY_FAST; // [RULE_12]
      secs  <= 17'd0;
      tries <= 5'd0;
    end else if (rif.manual_clr) begin
      state <= pfp_pkg::PFP_RETRY_IDLE; // [RULE_02]
    end else if (rif.tick && timing) begin
      if (secs + 17'd1 >= interval) begin
        secs <= 17'd0;
        if (!rif.cond) begin
          state <= pfp_pkg::PFP_RETRY_IDLE; // [RULE_11] [RULE_10]
        end else if (tries + 5'd1 == limit) begin
          tries <= 5'd0;
          unique case (state)
            pfp_pkg::PFP_RETRY_FAST:   state <= pfp_pkg::PFP_RETRY_HOURLY; // [RULE_12]
            pfp_pkg::PFP_RETRY_HOURLY: state <= pfp_pkg::PFP_RETRY_DAILY;
            default:                   state <= pfp_pkg::PFP_RETRY_SPENT;
          endcase
        end else begin
          tries <= tries + 5'd1;
        end
      end else begin
        secs <= secs + 17'd1; // [RULE_16]
      end
    end
  end
endmodule

/* File: hw/pfp_manager.sv */
// Purpose: fault-protection manager of an inverter-driven water pump
// Assumes: sensor and key pins are asynchronous; APB master on the same clock
// Notes:   zero-wait APB slave, one register word per aligned address
`timescale 1ns/1ps
`include "pfp_defines.svh"

// Operation
// RULE_01 - dry run past delay blocks, alarms, shows code
// RULE_02 - plus/minus release clears error, forces retry
// RULE_03 - leak cycling mode: off, basic or smart
// RULE_04 - basic cycling blocks until manual key reset
// RULE_05 - smart cycling raises restart pressure drop
// RULE_06 - near freezing, run pump to warm water
// RULE_07 - pressure sensor fault blocks, clears itself
// RULE_08 - supply out of range blocks, auto clear only
// RULE_09 - phase short ignores keys for ten seconds
// RULE_10 - listed blockages reset themselves automatically
// RULE_11 - successful retry ends schedule, normal operation
// RULE_12 - retries: 10 min x6, hourly x24, daily x30
// RULE_13 - power stage overheat clears when temperature normal
// RULE_14 - display only highest priority active protection
// RULE_15 - internal error blocks fifteen minutes, then clears
// RULE_16 - timers advance on a one-second tick
module pfp_manager #(
  parameter int unsigned TICK_CYCLES = `PFP_TICK_PERIOD_NS / `PFP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // sensors and drive
  input  wire logic        water_lack,
  input  wire logic        leak_recur,
  input  wire logic        temp_near_freeze,
  input  wire logic        pressure_sensor_fault,
  input  wire logic        supply_out_of_range,
  input  wire logic        power_stage_overheat,
  input  wire logic        motor_overload,
  input  wire logic        phase_short,
  input  wire logic        internal_error,
  input  wire logic        pump_demand,
  // keypad
  input  wire logic        key_plus,
  input  wire logic        key_minus,
  // outputs
  output logic             pump_run,
  output logic             alarm_led,
  output logic      [3:0]  display_code,
  output logic             leak_cycling_message,
  output logic             irq
);
  // synchronised pins
  logic [11:0] pins;
  logic [11:0] s;
  logic s_water, s_leak, s_freeze, s_sensor, s_supply, s_overheat;
  logic s_overload, s_short, s_internal, s_demand, s_plus, s_minus;

  assign pins = {water_lack, leak_recur, temp_near_freeze, pressure_sensor_fault,
                 supply_out_of_range, power_stage_overheat, motor_overload, phase_short,
                 internal_error, pump_demand, key_plus, key_minus};
  assign {s_water, s_leak, s_freeze, s_sensor, s_supply, s_overheat,
          s_overload, s_short, s_internal, s_demand, s_plus, s_minus} = s;

  pfp_sync #(.W(12)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pins),
    .q     (s)
  );

  // registers
  pfp_pkg::pfp_cycle_mode_e cycle_mode;
  logic [15:0]              dry_run_delay;
  logic [7:0]               restart_pressure_drop;
  logic [7:0]               pressure_setpoint;
  logic [7:0]               irq_status;
  logic [7:0]               irq_mask;

  // protection state
  logic        tick;
  logic [31:0] tick_cnt;
  logic [15:0] dry_secs;
  logic        dry_trigger;
  logic        leak_q, short_q, internal_q;
  logic        cycling_block;
  logic        phase_short_block;
  logic [16:0] short_secs;
  logic        internal_block;
  logic [16:0] internal_secs;
  logic        keys_held;
  logic        manual;
  logic [7:0]  blocks;
  logic [7:0]  blocks_q;
  logic [7:0]  events;
  logic        dry_run_block;
  logic        motor_overload_block;
  pfp_pkg::pfp_code_e next_code;

  // apb decode
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_data;

  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr     = access && pwrite;

  // one-second tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000; // [RULE_16]
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // retry schedulers for dry run and motor overload
  pfp_retry_if dry_if ();
  pfp_retry_if ovl_if ();

  assign dry_if.tick       = tick;
  assign dry_if.trigger    = dry_trigger;
  assign dry_if.cond       = s_water;
  assign dry_if.manual_clr = manual;
  assign ovl_if.tick       = tick;
  assign ovl_if.trigger    = s_overload;
  assign ovl_if.cond       = s_overload;
  assign ovl_if.manual_clr = manual;
  assign dry_run_block        = dry_if.blocked;
  assign motor_overload_block = ovl_if.blocked;

  pfp_retry u_dry_retry (
    .clock (clock),
    .rst_n (rst_n),
    .rif   (dry_if.retry)
  );

  pfp_retry u_ovl_retry (
    .clock (clock),
    .rst_n (rst_n),
    .rif   (ovl_if.retry)
  );

  // water lack must persist for the configured delay
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dry_secs    <= 16'h0000;
      dry_trigger <= 1'b0;
    end else if (!s_water || dry_run_block) begin
      dry_secs    <= 16'h0000;
      dry_trigger <= 1'b0;
    end else if (tick) begin
      if (dry_secs + 16'h0001 >= dry_run_delay) begin
        dry_secs    <= 16'h0000;
        dry_trigger <= 1'b1; // [RULE_01]
      end else begin
        dry_secs    <= dry_secs + 16'h0001; // [RULE_16]
        dry_trigger <= 1'b0;
      end
    end else begin
      dry_trigger <= 1'b0;
    end
  end

  // manual reset on release of both keys after they were held together
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      keys_held <= 1'b0;
      manual    <= 1'b0;
    end else if (s_plus && s_minus) begin
      keys_held <= 1'b1;
      manual    <= 1'b0;
    end else if (keys_held && !s_plus && !s_minus) begin
      keys_held <= 1'b0;
      manual    <= 1'b1; // [RULE_02]
    end else begin
      manual    <= 1'b0;
    end
  end

  // edge memory for event inputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      leak_q     <= 1'b0;
      short_q    <= 1'b0;
      internal_q <= 1'b0;
    end else begin
      leak_q     <= s_leak;
      short_q    <= s_short;
      internal_q <= s_internal;
    end
  end

  // leak cycling in basic mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycling_block <= 1'b0;
    end else if (s_leak && !leak_q && cycle_mode == pfp_pkg::PFP_CYCLE_BASIC) begin
      cycling_block <= 1'b1; // [RULE_04] [RULE_03]
    end else if (manual) begin
      cycling_block <= 1'b0; // [RULE_02]
    end
  end

  // phase short: keys take effect only after the hold-off
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_short_block <= 1'b0;
      short_secs        <= 17'd0;
    end else if (s_short && !short_q) begin
      phase_short_block <= 1'b1;
      short_secs        <= 17'd0;
    end else begin
      if (tick && short_secs < `PFP_SHORT_HOLD_S) begin
        short_secs <= short_secs + 17'd1; // [RULE_16]
      end
      if (manual && short_secs >= `PFP_SHORT_HOLD_S) begin
        phase_short_block <= 1'b0; // [RULE_09]
      end
    end
  end

  // internal error: powered wait, then automatic clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      internal_block <= 1'b0;
      internal_secs  <= 17'd0;
    end else if (s_internal && !internal_q) begin
      internal_block <= 1'b1;
      internal_secs  <= 17'd0;
    end else if (internal_block && tick) begin
      if (internal_secs + 17'd1 >= `PFP_INTERNAL_HOLD_S) begin
        internal_block <= 1'b0; // [RULE_15]
        internal_secs  <= 17'd0;
      end else begin
        internal_secs  <= internal_secs + 17'd1;
      end
    end
  end

  // block vector; level blocks follow their conditions and ignore the keys
  always_comb begin
    blocks                    = 8'h00;
    blocks[`PFP_BIT_DRY]      = dry_run_block;
    blocks[`PFP_BIT_OVERLOAD] = motor_overload_block;
    blocks[`PFP_BIT_CYCLING]  = cycling_block;
    blocks[`PFP_BIT_SHORT]    = phase_short_block;
    blocks[`PFP_BIT_INTERNAL] = internal_block;
    blocks[`PFP_BIT_OVERHEAT] = s_overheat; // [RULE_13] [RULE_10]
    blocks[`PFP_BIT_SUPPLY]   = s_supply;   // [RULE_08]
    blocks[`PFP_BIT_SENSOR]   = s_sensor;   // [RULE_07]
  end

  // highest priority active protection
  always_comb begin
    if (blocks[`PFP_BIT_SHORT]) begin
      next_code = pfp_pkg::PFP_CODE_SHORT; // [RULE_14]
    end else if (blocks[`PFP_BIT_INTERNAL]) begin
      next_code = pfp_pkg::PFP_CODE_INTERNAL;
    end else if (blocks[`PFP_BIT_OVERHEAT]) begin
      next_code = pfp_pkg::PFP_CODE_OVERHEAT;
    end else if (blocks[`PFP_BIT_SUPPLY]) begin
      next_code = pfp_pkg::PFP_CODE_SUPPLY;
    end else if (blocks[`PFP_BIT_OVERLOAD]) begin
      next_code = pfp_pkg::PFP_CODE_OVERLOAD;
    end else if (blocks[`PFP_BIT_SENSOR]) begin
      next_code = pfp_pkg::PFP_CODE_SENSOR; // [RULE_07]
    end else if (blocks[`PFP_BIT_DRY]) begin
      next_code = pfp_pkg::PFP_CODE_DRY; // [RULE_01]
    end else if (blocks[`PFP_BIT_CYCLING]) begin
      next_code = pfp_pkg::PFP_CODE_CYCLING;
    end else begin
      next_code = pfp_pkg::PFP_CODE_NONE;
    end
  end

  // pump, indicator and display outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pump_run             <= 1'b0;
      alarm_led            <= 1'b0;
      display_code         <= 4'h0;
      leak_cycling_message <= 1'b0;
    end else begin
      pump_run             <= (s_demand || s_freeze) && (blocks == 8'h00); // [RULE_06] [RULE_01]
      alarm_led            <= (blocks != 8'h00); // [RULE_01] [RULE_04]
      display_code         <= next_code; // [RULE_14]
      leak_cycling_message <= cycling_block; // [RULE_04]
    end
  end

  // writable registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycle_mode        <= pfp_pkg::pfp_cycle_mode_e'(`PFP_RST_MODE);
      dry_run_delay     <= `PFP_RST_DRY_DELAY;
      pressure_setpoint <= `PFP_RST_SETPOINT;
      irq_mask          <= `PFP_RST_IRQ_MASK;
    end else if (wr) begin
      unique case (paddr)
        `PFP_ADDR_CTRL: begin
          if (pwdata[1:0] != 2'b11) begin
            cycle_mode <= pfp_pkg::pfp_cycle_mode_e'(pwdata[1:0]); // [RULE_03]
          end
        end
        `PFP_ADDR_DRY_DELAY: dry_run_delay     <= pwdata[15:0];
        `PFP_ADDR_SETPOINT:  pressure_setpoint <= pwdata[7:0];
        `PFP_ADDR_IRQ_MASK:  irq_mask          <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // restart pressure drop: smart cycling raises it, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      restart_pressure_drop <= `PFP_RST_RESTART_DROP;
    end else if (s_leak && !leak_q && cycle_mode == pfp_pkg::PFP_CYCLE_SMART) begin
      if (restart_pressure_drop <= 8'hFF - `PFP_RESTART_DROP_STEP) begin
        restart_pressure_drop <= restart_pressure_drop + `PFP_RESTART_DROP_STEP; // [RULE_05]
      end
    end else if (wr && paddr == `PFP_ADDR_RESTART_DROP) begin
      restart_pressure_drop <= pwdata[7:0];
    end
  end

  // sticky events, cleared by reading; a new event wins over the clear
  assign events = blocks & ~blocks_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blocks_q   <= 8'h00;
      irq_status <= 8'h00;
      irq        <= 1'b0;
    end else begin
      blocks_q <= blocks;
      if (access && !pwrite && paddr == `PFP_ADDR_IRQ_STATUS) begin
        irq_status <= events;
      end else begin
        irq_status <= irq_status | events;
      end
      irq <= ((irq_status | events) & irq_mask) != 8'h00;
    end
  end

  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    unique case (paddr)
      `PFP_ADDR_CTRL:         rd_data[1:0]  = cycle_mode;
      `PFP_ADDR_DRY_DELAY:    rd_data[15:0] = dry_run_delay;
      `PFP_ADDR_RESTART_DROP: rd_data[7:0]  = restart_pressure_drop;
      `PFP_ADDR_SETPOINT:     rd_data[7:0]  = pressure_setpoint;
      `PFP_ADDR_STATUS: begin
        rd_data[7:0]                                        = blocks;
        rd_data[`PFP_STATUS_RUN_BIT]                        = pump_run;
        rd_data[`PFP_STATUS_CODE_LSB+3:`PFP_STATUS_CODE_LSB] = display_code;
      end
      `PFP_ADDR_IRQ_STATUS:   rd_data[7:0]  = irq_status;
      `PFP_ADDR_IRQ_MASK:     rd_data[7:0]  = irq_mask;
      default:                mapped        = 1'b0;
    endcase
  end

  // apb answer: ready in the cycle after setup
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

/* File: verification/pfp_manager_asserts.sv */
// Purpose: port-level checker of the pump fault-protection manager
// Assumes: pin inputs reach outputs within five cycles
// Notes:   bound to every pfp_manager instance
`timescale 1ns/1ps
module pfp_manager_asserts #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pressure_sensor_fault,
  input wire logic       supply_out_of_range,
  input wire logic       power_stage_overheat,
  input wire logic       temp_near_freeze,
  input wire logic       pump_run,
  input wire logic       alarm_led,
  input wire logic [3:0] display_code,
  input wire logic       leak_cycling_message
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] short_age;
  // cycles the short code has been shown
  always_ff @(posedge clock) begin
    if (display_code != pfp_pkg::PFP_CODE_SHORT) short_age <= '0;
    else short_age <= short_age + 32'd1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_freeze_free;
    temp_near_freeze[*6] ##0 (!alarm_led)[*3];
  endsequence
  property p_apb_ready;
    s_setup |=> pready;
  endproperty
  property p_sensor_block;
    pressure_sensor_fault[*6] |-> alarm_led && !pump_run;
  endproperty
  property p_supply_block;
    supply_out_of_range[*6] |-> alarm_led && !pump_run;
  endproperty
  property p_overheat_block;
    power_stage_overheat[*6] |-> alarm_led && !pump_run;
  endproperty
  property p_blocked_stops;
    alarm_led |-> !pump_run;
  endproperty
  property p_code_alarm;
    alarm_led == (display_code != pfp_pkg::PFP_CODE_NONE);
  endproperty
  property p_cycling_msg;
    (display_code == pfp_pkg::PFP_CODE_CYCLING) |-> leak_cycling_message && alarm_led;
  endproperty
  property p_freeze_run;
    s_freeze_free |-> pump_run;
  endproperty
  property p_short_hold;
    $fell(display_code == pfp_pkg::PFP_CODE_SHORT) |-> short_age >= 9 * TICK_CYCLES - 2;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("pready missing after setup");
  a_sensor_block: assert property (p_sensor_block)
    else $error("sensor fault not blocking");
  a_supply_block: assert property (p_supply_block)
    else $error("supply fault not blocking");
  a_overheat_block: assert property (p_overheat_block)
    else $error("overheat not blocking");
  a_blocked_stops: assert property (p_blocked_stops)
    else $error("pump runs while blocked");
  a_code_alarm: assert property (p_code_alarm)
    else $error("alarm and code disagree");
  a_cycling_msg: assert property (p_cycling_msg)
    else $error("cycling code without message");
  a_freeze_run: assert property (p_freeze_run)
    else $error("pump idle near freezing");
  a_short_hold: assert property (p_short_hold)
    else $error("short block cleared early");
endmodule
bind pfp_manager pfp_manager_asserts #(.TICK_CYCLES(TICK_CYCLES)) pfp_manager_asserts_i (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pressure_sensor_fault(pressure_sensor_fault), .supply_out_of_range(supply_out_of_range),
  .power_stage_overheat(power_stage_overheat), .temp_near_freeze(temp_near_freeze),
  .pump_run(pump_run), .alarm_led(alarm_led), .display_code(display_code),
  .leak_cycling_message(leak_cycling_message));

/* File: verification/pfp_far_side.sv */
// Purpose: sensors and keypad facing the manager
// Assumes: cond bits 0..8 are dry, leak, freeze, sensor, supply, heat, load, short, internal
// Notes:   one key request gives six cycles of both keys then release
`timescale 1ns/1ps
module pfp_far_side (
  input  wire logic       clock,
  input  wire logic [8:0] cond,
  input  wire logic       key_req,
  output logic      [8:0] pins,
  output logic            key_plus,
  output logic            key_minus,
  output logic            key_done
);
  logic [3:0] kc = 4'h0;
  initial {pins, key_plus, key_minus, key_done} = '0;
  always @(posedge clock) begin
    pins <= cond;
    key_done <= (kc == 4'h1);
    if (kc != 4'h0) kc <= kc - 4'h1;
    else if (key_req) kc <= 4'hC;
    key_plus <= (kc > 4'h6);
    key_minus <= (kc > 4'h6);
  end
endmodule

/* File: verification/pump_fault_protection_manager_tb.sv */
// Purpose: self-checking bench of the fault-protection manager
// Assumes: one tick every ten cycles
// Notes:   table rows first, then hand-written cases
`timescale 1ns/1ps
`include "pfp_defines.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pump_fault_protection_manager_tb;
  logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, key_req = 0, er;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, pump_run, alarm_led, msg, irq, kp, km, kd;
  logic [3:0]  code;
  logic [8:0]  cond = '0, pins;
  int          checks = 0, n_mismatch = 0, cyc = 0;
  logic [8:0]  r_in [5] = '{9'h008, 9'h010, 9'h020, 9'h018, 9'h004};
  logic [4:0]  r_out [5] = '{5'h06, 5'h04, 5'h03, 5'h04, 5'h10};
  logic [7:0]  g_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C};
  logic [31:0] g_v [6] = '{32'h0, 32'hA, 32'h3, 32'h1E, 32'h0, 32'h0};
  always #5 clock = ~clock;
  pfp_far_side pfp_far_side_i (.clock(clock), .cond(cond), .key_req(key_req), .pins(pins),
    .key_plus(kp), .key_minus(km), .key_done(kd));
  pfp_manager #(.TICK_CYCLES(10)) pfp_manager_i (.clock(clock), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .water_lack(pins[0]), .leak_recur(pins[1]),
    .temp_near_freeze(pins[2]), .pressure_sensor_fault(pins[3]),
    .supply_out_of_range(pins[4]), .power_stage_overheat(pins[5]),
    .motor_overload(pins[6]), .phase_short(pins[7]), .internal_error(pins[8]),
    .pump_demand(1'b0), .key_plus(kp), .key_minus(km), .pump_run(pump_run),
    .alarm_led(alarm_led), .display_code(code), .leak_cycling_message(msg), .irq(irq));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic cw(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task automatic keys();
    key_req <= 1;
    @(posedge clock);
    key_req <= 0;
    while (kd !== 1'b1) @(posedge clock);
    cw(8);
  endtask
  task automatic pulse(input logic [8:0] c);
    cond <= c; cw(4); cond <= '0; cw(8);
  endtask
  initial begin
    cw(8); rst_n <= 1; cw(3);
    `CHK("run", 1'b0, pump_run)
    for (int i = 0; i < 6; i++) begin
      apb(0, g_a[i], '0);
      `CHK("reg", g_v[i], rd)
      `CHK("err", (i == 5), er)
    end
    for (int i = 0; i < 5; i++) begin
      cond <= r_in[i]; cw(8);
      `CHK("row", r_out[i], {pump_run, code})
      `CHK("irq", 1'b0, irq)
      cond <= '0; cw(8);
      `CHK("clear", 5'h00, {pump_run, code})
    end
    cond <= 9'h010; cw(8); keys();
    `CHK("supply", pfp_pkg::PFP_CODE_SUPPLY, code)
    cond <= '0; cw(8);
    for (int m = 0; m < 3; m++) begin
      apb(1, `PFP_ADDR_CTRL, m); pulse(9'h002); cw(30);
      `CHK("cyc", (m == 1) ? 4'h8 : 4'h0, code)
      `CHK("msg", (m == 1), msg)
      apb(0, `PFP_ADDR_RESTART_DROP, '0);
      `CHK("drop", 32'h3 + (m == 2), rd)
      keys();
      `CHK("key", pfp_pkg::PFP_CODE_NONE, code)
    end
    apb(0, `PFP_ADDR_IRQ_STATUS, '0);
    apb(1, `PFP_ADDR_IRQ_MASK, 32'h80); cond <= 9'h008; cw(8);
    `CHK("irq", 1'b1, irq)
    apb(0, `PFP_ADDR_IRQ_STATUS, '0); cw(3);
    `CHK("ist", 1'b1, rd[7])
    `CHK("irq", 1'b0, irq)
    pulse(9'h080);
    `CHK("sc", pfp_pkg::PFP_CODE_SHORT, code)
    keys();
    `CHK("sc", pfp_pkg::PFP_CODE_SHORT, code)
    cw(100); keys();
    `CHK("sc", pfp_pkg::PFP_CODE_NONE, code)
    apb(1, `PFP_ADDR_DRY_DELAY, 32'h3); cond <= 9'h001; cw(12);
    `CHK("dry", pfp_pkg::PFP_CODE_NONE, code)
    cw(50);
    `CHK("dry", 6'h17, {pump_run, alarm_led, code})
    cond <= '0; cw(5800);
    `CHK("dry", pfp_pkg::PFP_CODE_DRY, code)
    for (int n = 0; n < 400 && code !== 4'h0; n++) cw(1);
    `CHK("retry", pfp_pkg::PFP_CODE_NONE, code)
    pulse(9'h100); keys();
    `CHK("int", pfp_pkg::PFP_CODE_INTERNAL, code)
    cw(8700);
    `CHK("int", pfp_pkg::PFP_CODE_INTERNAL, code)
    cw(400);
    `CHK("int", pfp_pkg::PFP_CODE_NONE, code)
    tally_and_finish();
  end
endmodule
